// >>> design/dfp_slave_port.sv
// DDR flash bus slave port: frame decode, read strobe, write hand-off, reset pins
//
// Behaviour
// - Chip select falling starts a transaction; rising ends it.
// - Command, address and data move on clock crossings.
// - Read strobe edges coincide with read data byte changes.
// - With phase clock enabled, read strobe follows the phase-shifted clock.
// - Open-drain interrupt pulled low after an internal event.
// - Reset pin low reinitialises device to array read; unconnected reads high.
// - Reset pin low places strobe and data lines in high impedance.
// - Reset output low during power-on, released after configured timeout.
// - Release of reset output enters standby at once.
// - First three clocks carry three command/address words on six edges.
// - One address space; register-space bit is ignored.
// - Writes deposit address and data into the command buffer.
// - Reads return array data or an overlaid register window.
// - Burst type ignored on writes; one data word per write.
// - Sixteen-bit words: high byte on rising edge, low byte on falling.
// - Bit 47 direction, bit 46 space, bit 45 burst type.
// - Bits 2-0 start word in half-page; bits 38-16 half-page address.
// - After latency, strobe toggles and new byte follows each transition.
// - Latency code 0 gives 5 clocks, up to code 11 giving 16.
`timescale 1ns/1ns
module dfp_slave_port import dfp_pkg::*; #(
    parameter int RST_OUT_DEFAULT = RST_OUT_CYCLES
) (
    // System clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    // Link pins
    input wire logic ck_in,
    input wire logic cs_n_in,
    input wire logic strobe_phase_clock_in,
    input wire logic [BYTE_W-1:0] dq_in,
    output logic [BYTE_W-1:0] dq_out,
    output logic dq_oe_out,
    output logic rwds_out,
    output logic rwds_oe_out,
    // Reset and interrupt pins
    input wire logic hw_reset_n_in,
    output logic int_n_out,
    output logic int_oe_out,
    output logic system_reset_out_n_out,
    output logic system_reset_oe_out,
    // Configuration, read latency and strobe source
    input wire logic [3:0] lat_code_in,
    input wire logic phase_strobe_en_in,
    input wire logic [RST_OUT_CNT_W-1:0] rst_out_timeout_in,
    // Array and overlay window read path, link clock
    output logic [ADDR_W-1:0] arr_addr_out,
    input wire logic [WORD_W-1:0] arr_word_in,
    // Command buffer writes and device status, system clock
    output logic cmd_wr_out,
    output logic [ADDR_W-1:0] cmd_addr_out,
    output logic [WORD_W-1:0] cmd_data_out,
    input wire logic int_event_in,
    input wire logic int_clear_in,
    output logic standby_out,
    output logic hw_reset_active_out
);
    // Default timeout must fit the hold counter
    if (RST_OUT_DEFAULT < 1 || RST_OUT_DEFAULT >= 2 ** RST_OUT_CNT_W) begin : g_bad_default
        $error("RST_OUT_DEFAULT must fit the timeout counter");
    end

    // Link-side synchronisers for static configuration and reset pin
    logic [5:0] lk_s1_r, lk_s2_r;
    always_ff @(posedge ck_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lk_s1_r <= '0;
            lk_s2_r <= '0;
        end else begin
            lk_s1_r <= {hw_reset_n_in, phase_strobe_en_in, lat_code_in};
            lk_s2_r <= lk_s1_r;
        end
    end
    logic lk_pin_ok, lk_phase_en;
    logic [3:0] lk_code;
    logic [4:0] lat_clocks;
    assign lk_pin_ok = lk_s2_r[5];
    assign lk_phase_en = lk_s2_r[4];
    assign lk_code = lk_s2_r[3:0];
    // Reserved codes fall back to the longest latency, the only safe choice
    assign lat_clocks = (lk_code > LAT_CODE_MAX) ? LAT_MAX : LAT_BASE + {1'b0, lk_code};

    // Frame logic is held reset while chip select is high
    logic lk_rst_b;
    assign lk_rst_b = rst_b_in & ~cs_n_in;

    // DDR byte capture
    logic [BYTE_W-1:0] hi_r, lo_r;
    always_ff @(posedge ck_in or negedge lk_rst_b) begin
        if (!lk_rst_b) hi_r <= '0;
        else hi_r <= dq_in;
    end
    always_ff @(negedge ck_in or negedge lk_rst_b) begin
        if (!lk_rst_b) lo_r <= '0;
        else lo_r <= dq_in;
    end
    logic [WORD_W-1:0] in_word;
    assign in_word = {hi_r, lo_r};

    dfp_link_state_type st_r, st_nxt;
    logic [1:0] cyc_r, cyc_nxt;
    logic [CA_W-1:0] ca_r, ca_nxt;
    logic [4:0] lat_r, lat_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [WORD_W-1:0] rd_word_r, rd_word_nxt;
    logic linear_r, linear_nxt;
    logic wr_go;
    logic [ADDR_W+WORD_W-1:0] wr_pack;
    logic [CA_W-1:0] ca_full;
    logic [ADDR_W-1:0] addr_inc;

    assign ca_full = {ca_r[CA_W-WORD_W-1:0], in_word};
    // Wrapped bursts stay inside the half-page
    assign addr_inc = linear_r ? addr_r + 1'b1 :
        {addr_r[ADDR_W-1:WRAP_W], addr_r[WRAP_W-1:0] + 1'b1};

    always_comb begin
        st_nxt = st_r;
        cyc_nxt = cyc_r;
        ca_nxt = ca_r;
        lat_nxt = lat_r;
        addr_nxt = addr_r;
        rd_word_nxt = rd_word_r;
        linear_nxt = linear_r;
        wr_go = 1'b0;
        case (st_r)
            DFP_CA: begin
                cyc_nxt = cyc_r + 2'd1;
                if (cyc_r != 2'd0) ca_nxt = ca_full;
                if (cyc_r == 2'(CA_WORDS)) begin
                    // Space bit is never looked at
                    addr_nxt = {ca_full[CA_HALF_HI:CA_HALF_LO], ca_full[CA_WORD_HI:0]};
                    linear_nxt = ca_full[CA_BURST_BIT];
                    lat_nxt = lat_clocks;
                    st_nxt = ca_full[CA_DIR_BIT] ? DFP_LAT : DFP_WR;
                end
            end
            DFP_LAT: begin
                lat_nxt = lat_r - 5'd1;
                if (lat_r == 5'd1) begin
                    rd_word_nxt = arr_word_in;
                    addr_nxt = addr_inc;
                    st_nxt = DFP_RD;
                end
            end
            DFP_RD: begin
                rd_word_nxt = arr_word_in;
                addr_nxt = addr_inc;
            end
            DFP_WR: begin
                wr_go = 1'b1;
                st_nxt = DFP_END;
            end
            DFP_END: begin
                st_nxt = DFP_END;
            end
            default: begin
                st_nxt = DFP_END;
            end
        endcase
    end

    always_ff @(posedge ck_in or negedge lk_rst_b) begin
        if (!lk_rst_b) begin
            st_r <= DFP_CA;
            cyc_r <= 2'd0;
            ca_r <= '0;
            lat_r <= 5'd0;
            addr_r <= '0;
            rd_word_r <= '0;
            linear_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cyc_r <= cyc_nxt;
            ca_r <= ca_nxt;
            lat_r <= lat_nxt;
            addr_r <= addr_nxt;
            rd_word_r <= rd_word_nxt;
            linear_r <= linear_nxt;
        end
    end

    assign arr_addr_out = addr_r;

    // Strobe reference: phase-shifted clock or main clock
    logic strobe_ref, rd_drive;
    assign strobe_ref = lk_phase_en ? strobe_phase_clock_in : ck_in;
    assign rd_drive = (st_r == DFP_RD) && lk_pin_ok && !cs_n_in;
    assign dq_out = strobe_ref ? rd_word_r[WORD_W-1:BYTE_W] : rd_word_r[BYTE_W-1:0];
    assign rwds_out = strobe_ref & (st_r == DFP_RD);
    assign dq_oe_out = rd_drive;
    assign rwds_oe_out = rd_drive;

    // Write word hand-off to the command buffer domain
    assign wr_pack = {addr_r, in_word};
    logic wr_vld;
    logic [ADDR_W+WORD_W-1:0] wr_word;
    dfp_word_xfer #(
        .DATA_W(ADDR_W + WORD_W)
    ) u_wr_xfer (
        .src_clk_in(ck_in),
        .src_rst_b_in(rst_b_in),
        .src_valid_in(wr_go),
        .src_data_in(wr_pack),
        .dst_clk_in(sys_clk_in),
        .dst_rst_b_in(rst_b_in),
        .dst_valid_out(wr_vld),
        .dst_data_out(wr_word)
    );
    assign cmd_wr_out = wr_vld & hw_reset_active_out == 1'b0;
    assign cmd_addr_out = wr_word[ADDR_W+WORD_W-1:WORD_W];
    assign cmd_data_out = wr_word[WORD_W-1:0];

    // System domain: reset pin, power-on reset output, interrupt
    logic rp_s1_r, rp_s2_r;
    logic por_r, por_nxt;
    logic [RST_OUT_CNT_W-1:0] por_cnt_r, por_cnt_nxt;
    logic loaded_r, loaded_nxt;
    logic int_r, int_nxt;
    logic stby_r, stby_nxt;

    always_comb begin
        por_nxt = por_r;
        por_cnt_nxt = por_cnt_r;
        loaded_nxt = 1'b1;
        stby_nxt = stby_r;
        if (!loaded_r) begin
            // Timeout caught once after reset release
            por_cnt_nxt = (rst_out_timeout_in == '0) ? RST_OUT_CNT_W'(RST_OUT_DEFAULT) : rst_out_timeout_in;
        end else if (por_r) begin
            por_cnt_nxt = por_cnt_r - 1'b1;
            if (por_cnt_r <= RST_OUT_CNT_W'(1)) begin
                por_nxt = 1'b0;
                stby_nxt = 1'b1;
            end
        end
        if (!rp_s2_r) stby_nxt = 1'b0;
        else if (!por_r) stby_nxt = 1'b1;
        // Set wins over clear
        int_nxt = int_event_in ? 1'b1 : (int_clear_in || !rp_s2_r) ? 1'b0 : int_r;
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rp_s1_r <= 1'b0;
            rp_s2_r <= 1'b0;
            por_r <= 1'b1;
            por_cnt_r <= '0;
            loaded_r <= 1'b0;
            int_r <= 1'b0;
            stby_r <= 1'b0;
        end else begin
            rp_s1_r <= hw_reset_n_in;
            rp_s2_r <= rp_s1_r;
            por_r <= por_nxt;
            por_cnt_r <= por_cnt_nxt;
            loaded_r <= loaded_nxt;
            int_r <= int_nxt;
            stby_r <= stby_nxt;
        end
    end

    assign int_n_out = 1'b0;
    assign int_oe_out = int_r;
    assign system_reset_out_n_out = 1'b0;
    assign system_reset_oe_out = por_r;
    assign standby_out = stby_r;
    assign hw_reset_active_out = ~rp_s2_r;

    // Link-domain checks
    sequence s_ca_read_done;
        st_r == DFP_CA && cyc_r == 2'd3 && ca_full[CA_DIR_BIT];
    endsequence
    sequence s_ca_write_done;
        st_r == DFP_CA && cyc_r == 2'd3 && !ca_full[CA_DIR_BIT];
    endsequence

    chk_ca_three_cycles: assert property (@(posedge ck_in) disable iff (!lk_rst_b)
        (st_r == DFP_CA && cyc_r == 2'd3) |=> st_r != DFP_CA)
        else $error("Command phase did not end after three words");
    chk_rd_latency_load: assert property (@(posedge ck_in) disable iff (!lk_rst_b)
        s_ca_read_done |=> (st_r == DFP_LAT && lat_r == $past(lat_clocks) && lat_r >= LAT_BASE))
        else $error("Read latency not loaded from code");
    chk_rd_latency_end: assert property (@(posedge ck_in) disable iff (!lk_rst_b)
        (st_r == DFP_LAT && lat_r == 5'd1) |=> (st_r == DFP_RD && rd_word_r == $past(arr_word_in)))
        else $error("Read data did not start after latency");
    chk_wr_single_word: assert property (@(posedge ck_in) disable iff (!lk_rst_b)
        s_ca_write_done |=> st_r == DFP_WR ##1 st_r == DFP_END ##1 st_r == DFP_END)
        else $error("Write took more than one data word");
    chk_oe_only_read: assert property (@(posedge ck_in) disable iff (!lk_rst_b)
        dq_oe_out |-> (st_r == DFP_RD && rwds_oe_out))
        else $error("Data lines driven outside read phase");
    chk_reset_hiz: assert property (@(posedge ck_in) disable iff (!lk_rst_b)
        !lk_pin_ok |-> !dq_oe_out && !rwds_oe_out)
        else $error("Outputs driven during reset pin low");
    chk_wrap_half_page: assert property (@(posedge ck_in) disable iff (!lk_rst_b)
        (st_r == DFP_RD && !linear_r) |=> addr_r[ADDR_W-1:WRAP_W] == $past(addr_r[ADDR_W-1:WRAP_W]))
        else $error("Wrapped burst left its half-page");
    chk_strobe_phase: assert property (@(posedge ck_in) disable iff (!lk_rst_b)
        (st_r == DFP_RD && lk_phase_en) |-> rwds_out == strobe_phase_clock_in)
        else $error("Strobe not taken from phase clock");

    // System-domain checks
    chk_rst_out_standby: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        ($fell(system_reset_oe_out) && rp_s2_r) |-> standby_out)
        else $error("Standby not entered at reset output release");
    chk_int_set_wins: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        int_event_in |=> int_oe_out)
        else $error("Interrupt event lost");
    chk_hw_reset_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        (!rp_s2_r && !int_event_in) |=> !standby_out && !int_oe_out)
        else $error("Reset pin did not reinitialise status");
endmodule

// >>> design/dfp_pkg.sv
// Shared constants for the DDR flash bus slave port
package dfp_pkg;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int CA_W = 48;
    localparam int CA_WORDS = 3;
    // Command/address field positions
    localparam int CA_DIR_BIT = 47;
    localparam int CA_SPACE_BIT = 46;
    localparam int CA_BURST_BIT = 45;
    localparam int CA_HALF_LO = 16;
    localparam int CA_HALF_HI = 38;
    localparam int CA_WORD_HI = 2;
    // Word address: half-page bits above the 3-bit word-in-half-page field
    localparam int ADDR_W = CA_HALF_HI - CA_HALF_LO + 1 + CA_WORD_HI + 1;
    localparam int WRAP_W = CA_WORD_HI + 1;
    // Read latency coding
    localparam logic [3:0] LAT_CODE_MAX = 4'h000b;
    localparam logic [4:0] LAT_BASE = 5'h0005;
    localparam logic [4:0] LAT_MAX = 5'h0010;
    // Power-on reset output default hold time
    localparam int RST_OUT_TIME_NS = 1000;
    localparam int SYS_CLK_MHZ = 100;
    localparam int RST_OUT_CYCLES = (RST_OUT_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int RST_OUT_CNT_W = 16;
    typedef enum logic [2:0] {
        DFP_CA,
        DFP_LAT,
        DFP_RD,
        DFP_WR,
        DFP_END
    } dfp_link_state_type;
endpackage

// >>> design/dfp_word_xfer.sv
// Toggle handshake carrying one word from the link clock to the system clock
`timescale 1ns/1ns
module dfp_word_xfer #(
    parameter int DATA_W = 32
) (
    // Source side, link clock
    input wire logic src_clk_in,
    input wire logic src_rst_b_in,
    input wire logic src_valid_in,
    input wire logic [DATA_W-1:0] src_data_in,
    // Destination side, system clock
    input wire logic dst_clk_in,
    input wire logic dst_rst_b_in,
    output logic dst_valid_out,
    output logic [DATA_W-1:0] dst_data_out
);
    logic tog_r, tog_nxt;
    logic [DATA_W-1:0] hold_r, hold_nxt;
    logic s1_r, s2_r, s3_r;
    logic vld_r, vld_nxt;
    logic [DATA_W-1:0] out_r, out_nxt;

    if (DATA_W < 1) begin : g_bad_width
        $error("DATA_W must be positive");
    end

    always_comb begin
        tog_nxt = tog_r ^ src_valid_in;
        hold_nxt = src_valid_in ? src_data_in : hold_r;
    end

    always_ff @(posedge src_clk_in or negedge src_rst_b_in) begin
        if (!src_rst_b_in) begin
            tog_r <= 1'b0;
            hold_r <= '0;
        end else begin
            tog_r <= tog_nxt;
            hold_r <= hold_nxt;
        end
    end

    // Hold word is stable long before the toggle lands: one word per frame
    always_comb begin
        vld_nxt = s2_r ^ s3_r;
        out_nxt = vld_nxt ? hold_r : out_r;
    end

    always_ff @(posedge dst_clk_in or negedge dst_rst_b_in) begin
        if (!dst_rst_b_in) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            vld_r <= 1'b0;
            out_r <= '0;
        end else begin
            s1_r <= tog_r;
            s2_r <= s1_r;
            s3_r <= s2_r;
            vld_r <= vld_nxt;
            out_r <= out_nxt;
        end
    end

    assign dst_valid_out = vld_r;
    assign dst_data_out = out_r;
endmodule

// >>> dv/dfp_host_model.sv
// Host controller model: link clock, chip select, phase clock and data line
`timescale 1ns/1ns
module dfp_host_model import dfp_pkg::*; (
    // Link pins toward the device
    output logic ck_out,
    output logic cs_n_out,
    output logic phase_clk_out,
    output logic [BYTE_W-1:0] dq_line_out,
    // Device drive of the shared data line
    input wire logic [BYTE_W-1:0] dq_dev_in,
    input wire logic dq_oe_in,
    input wire logic rwds_in
);
    logic [BYTE_W-1:0] drv;
    logic ps_run;
    logic [WORD_W-1:0] rd_q [8];
    logic early_q [8];
    int lat_seen;
    int bad_strobe;

    initial begin
        ck_out = 1'b0;
        cs_n_out = 1'b1;
        phase_clk_out = 1'b0;
        drv = 8'h00;
        ps_run = 1'b0;
        bad_strobe = 0;
    end

    // Released line shows the host's own current byte drv, never a held device value
    assign dq_line_out = dq_oe_in ? dq_dev_in : drv;

    // Phase clock lags by a quarter period; held low outside reads
    always @(ck_out) phase_clk_out <= #3 ck_out & ps_run;

    // One clock, a byte centred on each edge
    task automatic clk2(input logic [7:0] hi, input logic [7:0] lo, input int q);
        drv = hi;
        #q ck_out = 1'b1;
        #q drv = lo;
        #q ck_out = 1'b0;
        #q;
    endtask

    task automatic idle(input int n);
        repeat (n) clk2(~drv, drv, 3);
    endtask

    task automatic start_ca(input logic [CA_W-1:0] ca);
        cs_n_out = 1'b0;
        for (int i = 0; i < CA_WORDS; i++) begin
            clk2(ca[47-16*i -: 8], ca[39-16*i -: 8], 3);
        end
    endtask

    task automatic stop();
        #3 cs_n_out = 1'b1;
        #3;
    endtask

    // Second word is sent on purpose: the device must drop it; a burst may run at 50 MHz at most
    task automatic write_frame(input logic [CA_W-1:0] ca, input logic [WORD_W-1:0] d);
        start_ca(ca);
        clk2(d[15:8], d[7:0], 5);
        clk2(~d[15:8], ~d[7:0], 5);
        stop();
    endtask

    task automatic read_frame(input logic [CA_W-1:0] ca, input int n, input logic phase_on);
        int w;
        w = 0;
        lat_seen = -1;
        ps_run = phase_on;
        start_ca(ca);
        // Keep clocking through latency, bounded
        for (int j = 0; j < 40 && w < n; j++) begin
            drv = ~drv;
            #0 ck_out = 1'b1;
            #1;
            if (w == 0 && dq_oe_in === 1'b1) lat_seen = j;
            if (lat_seen >= 0) early_q[w] = rwds_in;
            #3;
            if (lat_seen >= 0) rd_q[w][15:8] = dq_line_out;
            if (lat_seen >= 0 && rwds_in !== 1'b1) bad_strobe++;
            #2 ck_out = 1'b0;
            #5;
            if (lat_seen >= 0) rd_q[w][7:0] = dq_line_out;
            if (lat_seen >= 0 && rwds_in !== 1'b0) bad_strobe++;
            if (lat_seen >= 0) w++;
            #1;
        end
        ps_run = 1'b0;
        stop();
    endtask
endmodule

// >>> dv/tb_ddr_flash_bus_slave_port.sv
// Self-checking bench for the DDR flash bus slave port
`timescale 1ns/1ns
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_ddr_flash_bus_slave_port import dfp_pkg::*;;
    logic sys_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic hw_reset_n_in = 1'b1;
    logic [3:0] lat_code_in = 4'h0;
    logic phase_strobe_en_in = 1'b0;
    logic [RST_OUT_CNT_W-1:0] rst_out_timeout_in = 16'h0005;
    logic int_event_in = 1'b0;
    logic int_clear_in = 1'b0;
    wire logic ck, cs_n, phase_clk, rwds_out, rwds_oe_out, dq_oe_out, int_n_out, int_oe_out;
    wire logic system_reset_out_n_out, system_reset_oe_out, cmd_wr_out, standby_out, hw_reset_active_out;
    wire logic [BYTE_W-1:0] dq_line, dq_out;
    wire logic [ADDR_W-1:0] arr_addr_out, cmd_addr_out;
    wire logic [WORD_W-1:0] arr_word_in, cmd_data_out;
    int n_errors = 0;
    int tests_run = 0;
    int n_wr = 0;
    int cnt;
    logic [ADDR_W-1:0] wr_addr, base, a;
    logic [WORD_W-1:0] wr_data;
    logic [3:0] lc [4] = '{4'h0, 4'hb, 4'hc, 4'h3};
    logic bt [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    logic pe [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    int exp_lat [4] = '{5, 16, 16, 8};

    always #5 sys_clk_in = ~sys_clk_in;

    // Array stand-in: word value is a fixed function of its address
    assign arr_word_in = arr_addr_out[15:0] ^ 16'h5a5a;

    dfp_host_model host (.ck_out(ck), .cs_n_out(cs_n), .phase_clk_out(phase_clk), .dq_line_out(dq_line),
        .dq_dev_in(dq_out), .dq_oe_in(dq_oe_out), .rwds_in(rwds_out));

    dfp_slave_port #(.RST_OUT_DEFAULT(100)) dut_u (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .ck_in(ck),
        .cs_n_in(cs_n), .strobe_phase_clock_in(phase_clk), .dq_in(dq_line), .dq_out(dq_out), .dq_oe_out(dq_oe_out),
        .rwds_out(rwds_out), .rwds_oe_out(rwds_oe_out), .hw_reset_n_in(hw_reset_n_in), .int_n_out(int_n_out),
        .int_oe_out(int_oe_out), .system_reset_out_n_out(system_reset_out_n_out),
        .system_reset_oe_out(system_reset_oe_out), .lat_code_in(lat_code_in),
        .phase_strobe_en_in(phase_strobe_en_in), .rst_out_timeout_in(rst_out_timeout_in),
        .arr_addr_out(arr_addr_out), .arr_word_in(arr_word_in), .cmd_wr_out(cmd_wr_out),
        .cmd_addr_out(cmd_addr_out), .cmd_data_out(cmd_data_out), .int_event_in(int_event_in),
        .int_clear_in(int_clear_in), .standby_out(standby_out), .hw_reset_active_out(hw_reset_active_out));

    always @(posedge sys_clk_in) begin
        if (cmd_wr_out === 1'b1) begin
            n_wr++;
            wr_addr = cmd_addr_out;
            wr_data = cmd_data_out;
        end
    end

    function automatic logic [CA_W-1:0] mk_ca(input logic rd, input logic sp, input logic bst,
        input logic [22:0] half, input logic [2:0] wd);
        return {rd, sp, bst, 6'h00, half, 13'h0000, wd};
    endfunction

    task automatic sys_wait(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        sys_wait(20);
        `CHK(system_reset_oe_out, 1'b1)
        `CHK(system_reset_out_n_out, 1'b0)
        `CHK(dq_oe_out, 1'b0)
        rst_b_in = 1'b1;
        for (cnt = 0; cnt < 50 && system_reset_oe_out === 1'b1; cnt++) begin
            `CHK(standby_out, 1'b0)
            sys_wait(1);
        end
        `CHK(cnt >= 5 && cnt <= 7, 1'b1)
        `CHK(standby_out, 1'b1)
        if (cnt >= 50) wrap_up();
        host.idle(3);
        // Write with space and burst bits set; both must be ignored
        host.write_frame(mk_ca(1'b0, 1'b1, 1'b1, 23'h12_3456, 3'h5), 16'hbeef);
        for (cnt = 0; cnt < 30 && n_wr == 0; cnt++) sys_wait(1);
        if (cnt >= 30) n_errors++;
        if (cnt >= 30) wrap_up();
        sys_wait(10);
        `CHK(n_wr, 1)
        `CHK(wr_addr, {23'h12_3456, 3'h5})
        `CHK(wr_data, 16'hbeef)
        base = {23'h01_a2b3, 3'h6};
        for (int t = 0; t < 4; t++) begin
            sys_wait(1);
            lat_code_in = lc[t];
            phase_strobe_en_in = pe[t];
            host.idle(3);
            host.read_frame(mk_ca(1'b1, t == 2, bt[t], base[25:3], base[2:0]), 3, pe[t]);
            `CHK(host.lat_seen, exp_lat[t])
            if (host.lat_seen < 0) wrap_up();
            `CHK(dq_oe_out, 1'b0)
            `CHK(rwds_oe_out, 1'b0)
            for (int i = 0; i < 3; i++) begin
                a = bt[t] ? base + ADDR_W'(i) : {base[25:3], base[2:0] + 3'(i)};
                `CHK(host.rd_q[i], a[15:0] ^ 16'h5a5a)
                `CHK(host.early_q[i], ~pe[t])
            end
        end
        `CHK(host.bad_strobe, 0)
        @(posedge sys_clk_in) #1 int_event_in = 1'b1;
        sys_wait(1);
        int_event_in = 1'b0;
        sys_wait(1);
        `CHK(int_oe_out, 1'b1)
        `CHK(int_n_out, 1'b0)
        int_clear_in = 1'b1;
        sys_wait(2);
        `CHK(int_oe_out, 1'b0)
        int_event_in = 1'b1;
        sys_wait(2);
        int_event_in = 1'b0;
        int_clear_in = 1'b0;
        `CHK(int_oe_out, 1'b1)
        // Reset pin low: state cleared and the read never drives the bus
        hw_reset_n_in = 1'b0;
        sys_wait(5);
        `CHK(hw_reset_active_out, 1'b1)
        `CHK(standby_out, 1'b0)
        `CHK(int_oe_out, 1'b0)
        lat_code_in = 4'h0;
        phase_strobe_en_in = 1'b0;
        host.read_frame(mk_ca(1'b1, 1'b0, 1'b1, base[25:3], base[2:0]), 1, 1'b0);
        `CHK(host.lat_seen, -1)
        sys_wait(1);
        hw_reset_n_in = 1'b1;
        sys_wait(5);
        `CHK(hw_reset_active_out, 1'b0)
        `CHK(standby_out, 1'b1)
        wrap_up();
    end
endmodule
